// ### tb/dio_fixture.sv
/*
 External fixture on the terminal block: drives chosen pins, makes pulses.
 Assumes the design output enable is high while the design drives a pin.
*/
`timescale 1ns/1ns
module dio_fixture (
   // Clock
   input wire i_mclk,
   // Design side of the pins
   input wire [6:0] i_pin_drv,
   input wire [6:0] i_pin_oe,
   // Resolved wire levels
   output wire [6:0] o_level
);
   reg [6:0] ext_en = 7'h40; // Pins the fixture drives, pin 7 at start
   reg [6:0] ext_val = 7'h40; // Levels it drives
   genvar g;
   //////////////////////////////////////////////////////////////////
   // Undriven lines are pulled up; a fight shows unknown
   generate for (g = 0; g < 7; g = g + 1) begin : g_wire
      assign o_level[g] = (i_pin_oe[g] && ext_en[g]) ? 1'bx : i_pin_oe[g] ? i_pin_drv[g] : ext_en[g] ? ext_val[g] : 1'b1;
   end endgenerate
   //////////////////////////////////////////////////////////////////
   // Set drive enables and levels just after an edge
   task set(input [6:0] en, input [6:0] val);
      begin
         @(posedge i_mclk);
         ext_en <= en;
         ext_val <= val;
      end
   endtask
   // Flip one pin, hold it, flip back
   task pulse(input integer idx, input integer width);
      begin
         @(posedge i_mclk);
         ext_val[idx] <= ~ext_val[idx];
         repeat (width) @(posedge i_mclk);
         ext_val[idx] <= ~ext_val[idx];
      end
   endtask
endmodule

// ### tb/dio_pins_props.sv
/*
 Checker for the digital I/O pin block: APB answer timing, protection latch,
 trigger input events and pin 7 quiet after reset.
 Assumes it is bound to dio_pins and sees only that module's ports.
*/
`timescale 1ns/1ns
module dio_pins_props #(
   parameter NCHAN = 4
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // APB
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire o_pready,
   input wire o_pslverr,
   // Pins and channel side
   input wire [6:0] i_pin,
   input wire [6:0] o_pin_oe,
   input wire [NCHAN-1:0] i_chan_fault,
   input wire o_trig_in_evt,
   input wire o_outputs_off,
   input wire o_protect
);
   wire wr_acc = i_psel && i_penable && i_pwrite; // Write access edge
   reg [6:0] prev_pin; // Pin levels one edge ago
   reg [7:0] since_chg; // Cycles since any pin changed, saturating
   reg any_wr; // A register write has happened
   //////////////////////////////////////////////////////////////////
   // Helper counters
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_pin <= 7'h00;
         since_chg <= 8'hff;
         any_wr <= 1'b0;
      end else begin
         prev_pin <= i_pin;
         since_chg <= (i_pin != prev_pin) ? 8'h00 : (since_chg == 8'hff ? since_chg : since_chg + 8'h01);
         any_wr <= any_wr | wr_acc;
      end
   end
   //////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   sequence s_answer;
      o_pready ##1 !o_pready;
   endsequence
   a_ready_wait: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 s_answer) else $error("ready timing");
   a_ready_idle: assert property (!i_psel |=> !o_pready) else $error("ready without select");
   a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
   a_fault_sets: assert property (|i_chan_fault |-> ##[1:3] o_protect) else $error("fault not latched");
   a_fault_holds: assert property (o_protect && |i_chan_fault |=> o_protect) else $error("fault released");
   a_clear_write: assert property ($fell(o_protect) |-> $past(wr_acc) || $past(wr_acc, 2)) else $error("no clear");
   a_inhibit_prot: assert property (o_outputs_off |-> ##[0:2] o_protect) else $error("inhibit unprotected");
   a_evt_single: assert property (o_trig_in_evt |=> !o_trig_in_evt) else $error("event too long");
   a_trig_latency: assert property (o_trig_in_evt |-> since_chg <= 8'd125) else $error("event late");
   a_pin7_quiet: assert property (!any_wr |-> !o_pin_oe[6]) else $error("pin 7 driven");
endmodule
bind dio_pins dio_pins_props #(.NCHAN(NCHAN)) u_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pin(i_pin),
   .o_pin_oe(o_pin_oe), .i_chan_fault(i_chan_fault), .o_trig_in_evt(o_trig_in_evt),
   .o_outputs_off(o_outputs_off), .o_protect(o_protect));

// ### tb/tb_dio_pins.sv
/*
 Testbench for the digital I/O pin block: APB tasks and pin scenarios.
 Assumes dio_fixture on the pins and the bound checker.
*/
`timescale 1ns/1ns
`include "dio_consts.vh"
module tb_dio_pins;
   reg i_mclk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_trig_out_evt = 0, perr;
   reg [11:0] i_paddr = 0;
   reg [31:0] i_pwdata = 0, rdat;
   reg [3:0] i_chan_fault = 0, i_chan_on = 0, i_chan_hv = 0;
   wire [31:0] o_prdata;
   wire o_pready, o_pslverr, o_trig_in_evt, o_outputs_off, o_protect, o_interlock_open;
   wire [6:0] pin_lvl, o_pin, o_pin_oe;
   integer miscompares = 0, total_checks = 0, evt_cnt = 0, n, k, j, c0;
   //////////////////////////////////////////////////////////////////
   initial forever #20 i_mclk = ~i_mclk; // 25 MHz
   always @(posedge i_mclk) if (o_trig_in_evt === 1'b1) evt_cnt <= evt_cnt + 1; // Event count
   dio_pins #(.CLK_HZ(25000000), .NCHAN(4)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pin(pin_lvl), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
      .i_chan_fault(i_chan_fault), .i_chan_on(i_chan_on), .i_chan_hv(i_chan_hv), .i_trig_out_evt(i_trig_out_evt),
      .o_trig_in_evt(o_trig_in_evt), .o_outputs_off(o_outputs_off), .o_protect(o_protect),
      .o_interlock_open(o_interlock_open));
   dio_fixture fx (.i_mclk(i_mclk), .i_pin_drv(o_pin), .i_pin_oe(o_pin_oe), .o_level(pin_lvl));
   //////////////////////////////////////////////////////////////////
   // Compare and count
   task chk(input string nm, input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // One APB transfer, waits for ready
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge i_mclk);
         i_psel <= 1'b1;
         i_pwrite <= w;
         i_paddr <= a;
         i_pwdata <= d;
         @(posedge i_mclk);
         i_penable <= 1'b1;
         @(posedge i_mclk);
         // Only the watchdog ends a wait for ready
         while (o_pready !== 1'b1) @(posedge i_mclk);
         rdat = o_prdata;
         perr = o_pslverr;
         i_psel <= 1'b0;
         i_penable <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [31:0] e, input string nm);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, rdat, e);
      end
   endtask
   task cyc(input integer c);
      repeat (c) @(posedge i_mclk);
   endtask
   // Verdict
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      #(40 * 20000);
      miscompares = miscompares + 1;
      stop_test;
   end
   //////////////////////////////////////////////////////////////////
   initial begin
      cyc(4);
      i_rst_n <= 1'b1;
      cyc(3);
      chk("oe_rst", o_pin_oe, 7'h3f);
      rd(`DIO_OFF_FUNC_HI, 32'h180, "func_hi");
      // Output data and polarity
      apb(1'b1, `DIO_OFF_OUT, 32'h25);
      apb(1'b1, `DIO_OFF_POL, 32'h01);
      cyc(3);
      chk("gpio", o_pin[5:0], 6'h24);
      rd(`DIO_OFF_IN, 32'h64, "in_gpio");
      // Inputs ignore output data
      apb(1'b1, `DIO_OFF_FUNC_LO, 32'h249);
      cyc(3);
      chk("oe_in", o_pin_oe[3:0], 4'h0);
      fx.set(7'h4f, 7'h4a);
      cyc(4);
      rd(`DIO_OFF_IN, 32'h6a, "in_ext");
      // Trigger input, rising then falling
      apb(1'b1, `DIO_OFF_FUNC_LO, 32'h24a);
      for (k = 0; k < 2; k = k + 1) begin
         fx.set(7'h4f, {6'h25, k[0]});
         apb(1'b1, `DIO_OFF_POL, k);
         cyc(10);
         c0 = evt_cnt;
         fork
            fx.pulse(0, k ? 250 : 100);
            begin
               j = 0;
               while (o_trig_in_evt !== 1'b1 && j < 130) begin
                  j = j + 1;
                  @(posedge i_mclk);
               end
               // Clear flags after the leading edge; the trailing one is judged alone
               apb(1'b1, `DIO_OFF_TRIG, 32'h7f7f);
            end
         join
         chk("trig_lat", j < 126, 1);
         cyc(150);
         chk("trig_cnt", evt_cnt - c0, 1);
         // Pulse of exactly the minimum width is not short; other edge raises nothing
         rd(`DIO_OFF_TRIG, 32'h0, "trig_flags");
      end
      // Negative pulse of 99 cycles, far under its 250-cycle minimum: event and short flag
      fx.pulse(0, 99);
      cyc(10);
      rd(`DIO_OFF_TRIG, 32'h101, "trig_short");
      // Trigger output width and sense; a second event mid-pulse is ignored
      fx.set(7'h4d, 7'h48);
      apb(1'b1, `DIO_OFF_FUNC_LO, 32'h259);
      for (k = 0; k < 2; k = k + 1) begin
         apb(1'b1, `DIO_OFF_POL, k << 1);
         cyc(5);
         chk("trig_idle", o_pin[1], k);
         i_trig_out_evt <= 1'b1;
         n = 0;
         for (j = 0; j < 400; j = j + 1) begin
            @(posedge i_mclk);
            i_trig_out_evt <= (j == 50);
            if (o_pin[1] !== k[0]) n = n + 1;
         end
         chk("trig_width", n, 250);
      end
      // Fault output latch
      fx.set(7'h48, 7'h48);
      apb(1'b1, `DIO_OFF_POL, 32'h0);
      apb(1'b1, `DIO_OFF_OUT, 32'h27);
      apb(1'b1, `DIO_OFF_FUNC_LO, 32'h304);
      cyc(3);
      chk("fault_oe", o_pin_oe[2:0], 3'h1);
      chk("fault_idle", o_pin[0], 0);
      i_chan_fault <= 4'h4;
      cyc(3);
      chk("fault_on", o_pin[0], 1);
      rd(`DIO_OFF_STAT, 32'h3, "stat");
      apb(1'b1, `DIO_OFF_CTRL, 32'h1);
      cyc(2);
      chk("fault_kept", o_pin[0], 1);
      i_chan_fault <= 4'h0;
      cyc(3);
      chk("fault_gone", o_pin[0], 1);
      apb(1'b1, `DIO_OFF_CTRL, 32'h1);
      cyc(3);
      chk("fault_clr", {o_pin[0], o_protect}, 0);
      // Inhibit, level sensitive with polarity
      fx.set(7'h4e, 7'h4a);
      apb(1'b1, `DIO_OFF_FUNC_LO, 32'h349);
      fx.set(7'h4f, 7'h4e);
      cyc(125);
      chk("inh_on", {o_outputs_off, o_protect}, 2'h3);
      fx.set(7'h4f, 7'h4a);
      cyc(125);
      chk("inh_off", {o_outputs_off, o_protect}, 2'h1);
      apb(1'b1, `DIO_OFF_POL, 32'h04);
      cyc(125);
      chk("inh_pol", o_outputs_off, 1);
      // Interlock on pin 7
      apb(1'b1, `DIO_OFF_CTRL, 32'h2);
      cyc(5);
      chk("ilk_closed", o_interlock_open, 0);
      fx.set(7'h4f, 7'h0a);
      apb(1'b1, `DIO_OFF_POL, 32'h40);
      cyc(5);
      chk("ilk_open", o_interlock_open, 1);
      fx.set(7'h4f, 7'h4a);
      cyc(5);
      chk("ilk_pol", o_interlock_open, 0);
      apb(1'b1, `DIO_OFF_FUNC_HI, 32'h040);
      cyc(5);
      chk("ilk_moved", o_interlock_open, 1);
      // High-voltage status on pin 4
      fx.set(7'h47, 7'h4a);
      apb(1'b1, `DIO_OFF_POL, 32'h0);
      apb(1'b1, `DIO_OFF_FUNC_LO, 32'he49);
      for (k = 0; k < 4; k = k + 1) begin
         i_chan_on <= {3'h0, k[1]};
         i_chan_hv <= {3'h0, k[0]};
         cyc(5);
         chk("hv", o_pin[3], k == 3);
      end
      // Unmapped address
      apb(1'b0, 12'h020, 32'h0);
      chk("slverr", perr, 1);
      stop_test;
   end
endmodule

// ### verilog/dio_consts.vh
/*
 Constants for the rear-panel digital I/O pin block: register offsets,
 pin function codes, field positions, reset values and timing figures.
 Assumes a 25 MHz system clock unless the module parameter says otherwise.
*/
`ifndef DIO_CONSTS_VH
`define DIO_CONSTS_VH

// Register byte offsets on the APB slave
`define DIO_OFF_FUNC_LO 12'h000
`define DIO_OFF_FUNC_HI 12'h004
`define DIO_OFF_POL 12'h008
`define DIO_OFF_OUT 12'h00c
`define DIO_OFF_IN 12'h010
`define DIO_OFF_CTRL 12'h014
`define DIO_OFF_STAT 12'h018
`define DIO_OFF_TRIG 12'h01c

// Pin function codes, three bits per pin
`define DIO_FN_GPIO 3'h0
`define DIO_FN_INPUT 3'h1
`define DIO_FN_TRIG_IN 3'h2
`define DIO_FN_TRIG_OUT 3'h3
`define DIO_FN_FAULT 3'h4
`define DIO_FN_INHIBIT 3'h5
`define DIO_FN_INTERLOCK 3'h6
`define DIO_FN_HV_STAT 3'h7

// Pin count and field layout
`define DIO_NPINS 7
`define DIO_FN_W 3
`define DIO_FUNC_RST 21'h180000
`define DIO_PIN_FAULT 0
`define DIO_PIN_COMMON 1
`define DIO_PIN_INHIBIT 2
`define DIO_PIN_ILOCK 6

// Control bits
`define DIO_CTRL_CLEAR 0
`define DIO_CTRL_ILOCK_EN 1

// Trigger flag register: too-short flags start at this bit
`define DIO_TRIG_SHORT_LSB 8

// Timing figures in nanoseconds
`define DIO_TRIG_PULSE_NS 10000
`define DIO_LATENCY_NS 5000
`define DIO_MIN_POS_NS 4000
`define DIO_MIN_NEG_NS 10000

`endif

// ### verilog/dio_pins.v
/*
 Rear-panel digital I/O pin block: seven configurable pins with polarity,
 trigger in/out, latched fault output, inhibit, interlock and high-voltage
 status, configured over an APB slave.
 Assumes pin inputs are asynchronous, channel status inputs share i_mclk.
*/
// Behaviour
// - Pins 1-7 each configurable GPIO with polarity
// - Pin n maps to data bit n-1
// - Input pin ignores output data, undriven
// - Status shows true external pin level
// - Trigger pins; positive rising, negative falling
// - Trigger input fires only on selected edge
// - Trigger event within 5 us
// - Trigger output gives one 10 us pulse
// - Trigger output pulse sense follows polarity
// - Fault output only pin 1, pin 2 common
// - Any channel fault asserts fault output
// - Fault holds until gone and software clears
// - Pin 2 output functions ignored while fault on
// - Inhibit only pin 3; shuts outputs, protects
// - Inhibit level-sensitive, polarity, within 5 us
// - Interlock only pin 7, default after reset
// - Interlock ignores pin 7 polarity
// - Interlock enabled, not configured: treat open
// - HV status when any channel on above 42 V
`timescale 1ns/1ns
`include "dio_consts.vh"
module dio_pins #(
   parameter CLK_HZ = 25000000,
   parameter NCHAN = 4
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // APB slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // Terminal pins 1..7 as bit 0..6
   input wire [6:0] i_pin,
   output reg [6:0] o_pin,
   output reg [6:0] o_pin_oe,
   // Channel side
   input wire [NCHAN-1:0] i_chan_fault,
   input wire [NCHAN-1:0] i_chan_on,
   input wire [NCHAN-1:0] i_chan_hv,
   input wire i_trig_out_evt,
   output reg o_trig_in_evt,
   output reg o_outputs_off,
   output reg o_protect,
   output reg o_interlock_open
);

////////////////////////////////////////////////////////////////////////////////
// Cycle counts derived from the clock rate
// Latency is a longest time, rounded down; widths are least times, rounded up
localparam integer TRIG_CYC = (`DIO_TRIG_PULSE_NS * (CLK_HZ / 1000) + 999999) / 1000000;
localparam integer LAT_CYC = (`DIO_LATENCY_NS * (CLK_HZ / 1000)) / 1000000;
localparam integer POS_CYC = (`DIO_MIN_POS_NS * (CLK_HZ / 1000) + 999999) / 1000000;
localparam integer NEG_CYC = (`DIO_MIN_NEG_NS * (CLK_HZ / 1000) + 999999) / 1000000;

// Function code of one pin from the packed function word
function [2:0] fn_of;
   input [20:0] word;
   input integer idx;
   begin
      fn_of = word[idx*`DIO_FN_W +: `DIO_FN_W];
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [20:0] func;          // Function code per pin
reg [6:0] pol;            // 1 = negative polarity per pin
reg [6:0] out_data;       // Output data, pin n at bit n-1
reg ilock_en;             // Mainframe interlock function enable
reg fault_latch;          // Latched fault output state
reg [6:0] sync1;          // First synchroniser stage
reg [6:0] sync2;          // Second synchroniser stage
reg [6:0] prev;           // Previous synchronised level
reg [6:0] trig_seen;      // Sticky trigger-in events for software
reg [6:0] short_seen;     // Sticky too-short pulse flags
reg [15:0] width_cnt [0:6]; // Level run length per pin
reg sw_clear;             // One-cycle protection clear pulse

// Combinational helpers
// Decode in the first access cycle; a write lands as the transfer completes
wire apb_acc = i_psel && i_penable && !o_pready;
wire apb_wr = i_psel && i_penable && i_pwrite && o_pready;
wire any_fault = |i_chan_fault;
wire [6:0] trig_act;
wire fault_mode = (fn_of(func, `DIO_PIN_FAULT) == `DIO_FN_FAULT);
wire inh_mode = (fn_of(func, `DIO_PIN_INHIBIT) == `DIO_FN_INHIBIT);
wire ilock_mode = (fn_of(func, `DIO_PIN_ILOCK) == `DIO_FN_INTERLOCK);
wire hv_active = |(i_chan_on & i_chan_hv);
// Logical pin levels after polarity
wire [6:0] logic_in = sync2 ^ pol;
// Inhibit active level, polarity applied
wire inh_level = logic_in[`DIO_PIN_INHIBIT];
reg [6:0] edge_hit;
reg [6:0] next_pin;
reg [6:0] next_oe;
// Separate loop indices, so no two processes share a variable
integer k;
integer ke;
integer kw;

////////////////////////////////////////////////////////////////////////////////
// Trigger output pulse generators, one per pin
genvar g;
generate
   for (g = 0; g < 7; g = g + 1) begin : tg
      dio_pulse_gen #(
         .CYCLES(TRIG_CYC)
      ) u_pulse (
         .i_mclk(i_mclk),
         .i_rst_n(i_rst_n),
         .i_start(i_trig_out_evt && fn_of(func, g) == `DIO_FN_TRIG_OUT),
         .o_active(trig_act[g])
      );
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for the pin inputs
always @(posedge i_mclk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      prev <= 7'h00;
   end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
      prev <= sync2;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Selected trigger edge per pin: rising when positive, falling when negative
always @* begin
   for (ke = 0; ke < 7; ke = ke + 1) begin
      edge_hit[ke] = (fn_of(func, ke) == `DIO_FN_TRIG_IN) &&
                     (pol[ke] ? (prev[ke] && !sync2[ke]) : (!prev[ke] && sync2[ke]));
   end
end

////////////////////////////////////////////////////////////////////////////////
// Run-length counters check the external pulse width before each edge
always @(posedge i_mclk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      for (kw = 0; kw < 7; kw = kw + 1) begin
         width_cnt[kw] <= 16'h0000;
      end
      short_seen <= 7'h00;
   end else begin
      for (kw = 0; kw < 7; kw = kw + 1) begin
         // Software clear first, so a flag raised in the same cycle wins
         if (apb_wr && i_paddr == `DIO_OFF_TRIG && i_pwdata[`DIO_TRIG_SHORT_LSB + kw]) begin
            short_seen[kw] <= 1'b0;
         end
         if (prev[kw] != sync2[kw]) begin
            // The new level has already stood for one cycle
            width_cnt[kw] <= 16'h0001;
            // Pulse that just ended was shorter than its minimum
            if (fn_of(func, kw) == `DIO_FN_TRIG_IN &&
                ((prev[kw] && width_cnt[kw] < POS_CYC[15:0]) ||
                 (!prev[kw] && width_cnt[kw] < NEG_CYC[15:0]))) begin
               short_seen[kw] <= 1'b1;
            end
         end else if (width_cnt[kw] != 16'hffff) begin
            width_cnt[kw] <= width_cnt[kw] + 16'h0001;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drive: per-function output level and enable
always @* begin
   for (k = 0; k < 7; k = k + 1) begin
      next_pin[k] = 1'b0;
      next_oe[k] = 1'b0;
      case (fn_of(func, k))
         `DIO_FN_GPIO: begin
            next_pin[k] = out_data[k] ^ pol[k];
            next_oe[k] = 1'b1;
         end
         `DIO_FN_TRIG_OUT: begin
            next_pin[k] = trig_act[k] ^ pol[k];
            next_oe[k] = 1'b1;
         end
         `DIO_FN_FAULT: begin
            // Only pin 1 may drive a fault
            if (k == `DIO_PIN_FAULT) begin
               next_pin[k] = fault_latch ^ pol[k];
               next_oe[k] = 1'b1;
            end
         end
         `DIO_FN_HV_STAT: begin
            next_pin[k] = hv_active ^ pol[k];
            next_oe[k] = 1'b1;
         end
         default: begin
            // Input-type functions never drive the pin
            next_pin[k] = 1'b0;
            next_oe[k] = 1'b0;
         end
      endcase
   end
   // Pin 2 is the isolated common while pin 1 carries the fault
   if (fault_mode) begin
      next_pin[`DIO_PIN_COMMON] = 1'b0;
      next_oe[`DIO_PIN_COMMON] = 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Registered pin drive
always @(posedge i_mclk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      o_pin <= 7'h00;
      o_pin_oe <= 7'h00;
   end else begin
      o_pin <= next_pin;
      o_pin_oe <= next_oe;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Trigger event, inhibit, interlock and fault latch
always @(posedge i_mclk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      o_trig_in_evt <= 1'b0;
      trig_seen <= 7'h00;
      o_outputs_off <= 1'b0;
      o_protect <= 1'b0;
      o_interlock_open <= 1'b0;
      fault_latch <= 1'b0;
   end else begin
      // Three cycles from pin to event, far inside LAT_CYC
      o_trig_in_evt <= |edge_hit;
      // Sticky capture, a new edge wins over a software clear
      if (apb_wr && i_paddr == `DIO_OFF_TRIG) begin
         trig_seen <= (trig_seen & ~i_pwdata[6:0]) | edge_hit;
      end else begin
         trig_seen <= trig_seen | edge_hit;
      end
      // Inhibit only on pin 3, level-sensitive
      o_outputs_off <= inh_mode && inh_level;
      // Interlock reads raw level, no polarity; unconfigured means open
      if (ilock_en) begin
         o_interlock_open <= ilock_mode ? !sync2[`DIO_PIN_ILOCK] : 1'b1;
      end else begin
         o_interlock_open <= 1'b0;
      end
      // Fault latch sets on any channel fault; both conditions release it
      if (any_fault) begin
         fault_latch <= 1'b1;
      end else if (sw_clear) begin
         fault_latch <= 1'b0;
      end
      // Protection state follows fault or inhibit, cleared by software
      if (any_fault || (inh_mode && inh_level)) begin
         o_protect <= 1'b1;
      end else if (sw_clear) begin
         o_protect <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// APB register writes
always @(posedge i_mclk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      func <= `DIO_FUNC_RST;
      pol <= 7'h00;
      out_data <= 7'h00;
      ilock_en <= 1'b0;
      sw_clear <= 1'b0;
   end else begin
      sw_clear <= 1'b0;
      if (apb_wr) begin
         case (i_paddr)
            `DIO_OFF_FUNC_LO: begin
               func[11:0] <= i_pwdata[11:0];
            end
            `DIO_OFF_FUNC_HI: begin
               func[20:12] <= i_pwdata[8:0];
            end
            `DIO_OFF_POL: begin
               pol <= i_pwdata[6:0];
            end
            `DIO_OFF_OUT: begin
               out_data <= i_pwdata[6:0];
            end
            `DIO_OFF_CTRL: begin
               sw_clear <= i_pwdata[`DIO_CTRL_CLEAR];
               ilock_en <= i_pwdata[`DIO_CTRL_ILOCK_EN];
            end
            default: begin
               sw_clear <= 1'b0;
            end
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// APB reads and handshake: one wait state, answer in the second access cycle
always @(posedge i_mclk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
   end else begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      if (apb_acc) begin
         case (i_paddr)
            `DIO_OFF_FUNC_LO: o_prdata <= {20'h00000, func[11:0]};
            `DIO_OFF_FUNC_HI: o_prdata <= {23'h000000, func[20:12]};
            `DIO_OFF_POL: o_prdata <= {25'h0000000, pol};
            `DIO_OFF_OUT: o_prdata <= {25'h0000000, out_data};
            // True pin level, no polarity applied
            `DIO_OFF_IN: o_prdata <= {25'h0000000, sync2};
            `DIO_OFF_CTRL: o_prdata <= {30'h00000000, ilock_en, 1'b0};
            `DIO_OFF_STAT: o_prdata <= {27'h0000000, hv_active, o_interlock_open,
                                        o_outputs_off, o_protect, fault_latch};
            `DIO_OFF_TRIG: o_prdata <= {17'h00000, short_seen, 1'b0, trig_seen};
            default: o_pslverr <= 1'b1;
         endcase
      end
   end
end

endmodule

// ### verilog/dio_pulse_gen.v
/*
 Trigger output pulse stretcher: each start pulse gives one active pulse of
 a fixed number of clock cycles. Start pulses during a pulse are ignored.
 Assumes the start input comes from the same clock domain.
*/
`timescale 1ns/1ns
module dio_pulse_gen #(
   parameter CYCLES = 250
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // Request and pulse
   input wire i_start,
   output reg o_active
);

// Down counter for the pulse width
reg [15:0] count;

////////////////////////////////////////////////////////////////////////////////
// Count the pulse width down from CYCLES - 1 to zero
always @(posedge i_mclk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      count <= 16'h0000;
      o_active <= 1'b0;
   end else if (i_start && !o_active) begin
      // Start a fresh pulse
      count <= CYCLES[15:0] - 16'h0001;
      o_active <= 1'b1;
   end else if (o_active) begin
      // Run down, release at zero
      if (count == 16'h0000) begin
         o_active <= 1'b0;
      end else begin
         count <= count - 16'h0001;
      end
   end
end

endmodule
